// >>> led_scan_pkg.sv
/*
  Constants, register layouts and state codes for the LED matrix frame and scan
  configuration block. Assumes a 50 MHz core clock.
*/
package led_scan_pkg;

  // Register offsets, reset values and writable-bit masks.
  localparam logic [7:0] REG_FRAME_HOLD = 8'h02;
  localparam logic [7:0] REG_DISP_OPT = 8'h03;
  localparam logic [7:0] REG_LAYOUT = 8'h04;
  localparam logic [7:0] FRAME_HOLD_RST = 8'h00;
  localparam logic [7:0] DISP_OPT_RST = 8'h07;
  localparam logic [7:0] LAYOUT_RST = 8'h00;
  localparam logic [7:0] FRAME_HOLD_MASK = 8'h0f;
  localparam logic [7:0] DISP_OPT_MASK = 8'h7f;
  localparam logic [7:0] LAYOUT_MASK = 8'h07;

  // Timing.
  localparam int CLK_HZ = 50_000_000;
  localparam int CLK_MHZ = 50;
  localparam int REFRESH_HZ = 430;
  localparam int LINES_ALL = 18;
  localparam int LINE_CYC = CLK_HZ / (REFRESH_HZ * LINES_ALL);
  localparam int FRAME_STEP_US = 32500;
  localparam int FRAME_STEP_CYC = FRAME_STEP_US * CLK_MHZ;
  localparam int BLINK_SHORT_MS = 1500;
  localparam int BLINK_LONG_MS = 3000;
  localparam int BLINK_SHORT_HALF_CYC = BLINK_SHORT_MS / 2 * 1000 * CLK_MHZ;
  localparam int BLINK_LONG_HALF_CYC = BLINK_LONG_MS / 2 * 1000 * CLK_MHZ;

  // Scan geometry and codes.
  localparam logic [3:0] MAX_K_TWO = 4'h8;
  localparam logic [3:0] MAX_K_THREE = 4'h5;
  localparam logic [4:0] GROUP1_FIRST = 5'h06;
  localparam logic [4:0] GROUP2_FIRST = 5'h0c;
  localparam logic [4:0] LINE_TOP = 5'h11;
  localparam logic [2:0] LAST_FRAME = 3'h5;
  localparam logic [1:0] SYNC_OUT = 2'b01;
  localparam logic [1:0] SYNC_IN = 2'b10;

  typedef struct packed {
    logic rsv;
    logic per_frame_int;
    logic start_off;
    logic long_blink;
    logic [3:0] scan_limit;
  } disp_opt_t;

  typedef struct packed {
    logic [4:0] rsv;
    logic [1:0] sync;
    logic two_matrix;
  } layout_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_MOVIE = 3'b010,
    ST_PICTURE = 3'b100
  } play_state_t;

  // Largest scan position actually used for a layout.
  function automatic logic [3:0] clamp_limit(input logic [3:0] code, input logic two);
    logic [3:0] top;
    top = two ? MAX_K_TWO : MAX_K_THREE;
    return (code > top) ? top : code;
  endfunction

endpackage

// >>> led_frame_scan.sv
/*
  Frame hold timing, line scan, blink and layout/sync setup of an LED matrix driver.
  Assumes a byte-wide register port fed by the serial front end, and all inputs
  synchronous to i_core_clk.
*/
`timescale 1ns/1ps
module led_frame_scan import led_scan_pkg::*; #(
  parameter int LINE_CYCLES = LINE_CYC,
  parameter int FRAME_STEP_CYCLES = FRAME_STEP_CYC,
  parameter int BLINK_SHORT_HALF = BLINK_SHORT_HALF_CYC,
  parameter int BLINK_LONG_HALF = BLINK_LONG_HALF_CYC
) (
  // Clock, reset, enable
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  // Register port
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  // Playback requests
  input wire logic i_movie_req,
  input wire logic i_picture_req,
  input wire logic [2:0] i_movie_start,
  input wire logic [2:0] i_movie_frames,
  input wire logic [2:0] i_picture_frame,
  input wire logic i_blink_en,
  // Sync pin
  input wire logic i_sync_in,
  output logic o_sync_out,
  output logic o_sync_oe,
  // Display drive
  output logic [4:0] o_line_sel,
  output logic [2:0] o_frame_sel,
  output logic [2:0] o_intensity_frame,
  output logic o_leds_on,
  output logic o_two_matrix,
  output logic o_movie_busy
);

  if (LINE_CYCLES < 4 || FRAME_STEP_CYCLES < 1 || BLINK_SHORT_HALF < 1 ||
      BLINK_LONG_HALF < 1) begin : g_bad_params
    $error("led_frame_scan: timing parameters out of range");
  end

  logic [7:0] frame_hold;
  disp_opt_t disp_opt;
  layout_t layout;
  logic [31:0] line_cnt, sub_cnt, blink_cnt;
  logic sync_prev, line_tick, refresh_pulse, hold_expire, blink_phase, movie_prev;
  logic [3:0] pos, lim, step, last_sum;
  logic [1:0] grp;
  logic [2:0] last_frame;
  play_state_t st;
  default clocking core_cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_sys_rst);

  // Register writes; reserved bits are never stored and read as zero.
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      frame_hold <= FRAME_HOLD_RST;
      disp_opt <= DISP_OPT_RST;
      layout <= LAYOUT_RST;
    end else if (i_clk_en && i_reg_wr) begin
      case (i_reg_addr)
        REG_FRAME_HOLD: frame_hold <= i_reg_wdata & FRAME_HOLD_MASK;
        REG_DISP_OPT: disp_opt <= i_reg_wdata & DISP_OPT_MASK;
        REG_LAYOUT: layout <= i_reg_wdata & LAYOUT_MASK;
        default: ;
      endcase
    end
  end

  // Register reads; unmapped addresses answer zero.
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_clk_en && i_reg_rd) begin
      case (i_reg_addr)
        REG_FRAME_HOLD: o_reg_rdata <= frame_hold;
        REG_DISP_OPT: o_reg_rdata <= disp_opt;
        REG_LAYOUT: o_reg_rdata <= layout;
        default: o_reg_rdata <= 8'h00;
      endcase
    end
  end

  // Line pacing: internal timer, or sync-pin rising edges, taken as already synchronous.
  assign line_tick = (layout.sync == SYNC_IN) ? (i_sync_in && !sync_prev)
                                              : (line_cnt == 32'(LINE_CYCLES - 1));

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      line_cnt <= 32'h0;
      sync_prev <= 1'b0;
      o_sync_out <= 1'b0;
      o_sync_oe <= 1'b0;
    end else if (i_clk_en) begin
      sync_prev <= i_sync_in;
      line_cnt <= (line_cnt == 32'(LINE_CYCLES - 1)) ? 32'h0 : line_cnt + 32'h1;
      // One rising edge per line so a follower steps in lockstep.
      o_sync_out <= (layout.sync == SYNC_OUT) && (line_cnt < 32'(LINE_CYCLES / 2));
      o_sync_oe <= (layout.sync == SYNC_OUT);
    end
  end

  // Scan walks 0..k, then 6..6+k and 12..12+k in three-matrix layout.
  // A layout change ends the current group at once, so no line of the old layout lingers.
  assign lim = clamp_limit(disp_opt.scan_limit, layout.two_matrix);

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pos <= 4'h0;
      grp <= 2'h0;
      o_line_sel <= 5'h00;
      refresh_pulse <= 1'b0;
      o_two_matrix <= 1'b0;
    end else if (i_clk_en) begin
      refresh_pulse <= 1'b0;
      o_two_matrix <= layout.two_matrix;
      if (line_tick || layout.two_matrix != o_two_matrix) begin
        if (pos >= lim || layout.two_matrix != o_two_matrix) begin
          pos <= 4'h0;
          if (layout.two_matrix || grp == 2'h2) begin
            grp <= 2'h0;
            o_line_sel <= 5'h00;
            refresh_pulse <= 1'b1;
          end else begin
            grp <= grp + 2'h1;
            o_line_sel <= (grp == 2'h0) ? GROUP1_FIRST : GROUP2_FIRST;
          end
        end else begin
          pos <= pos + 4'h1;
          o_line_sel <= o_line_sel + 5'h01;
        end
      end
    end
  end

  // Frame hold: a zero code lasts until the next refresh pulse, otherwise code steps.
  assign hold_expire = (frame_hold[3:0] == 4'h0) ? refresh_pulse
      : (sub_cnt == 32'(FRAME_STEP_CYCLES - 1) && step == frame_hold[3:0] - 4'h1);

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sub_cnt <= 32'h0;
      step <= 4'h0;
    end else if (i_clk_en) begin
      if (st != ST_MOVIE || hold_expire) begin
        sub_cnt <= 32'h0;
        step <= 4'h0;
      end else if (sub_cnt == 32'(FRAME_STEP_CYCLES - 1)) begin
        sub_cnt <= 32'h0;
        step <= step + 4'h1;
      end else begin
        sub_cnt <= sub_cnt + 32'h1;
      end
    end
  end

  // Last movie frame, capped at the top of frame memory.
  assign last_sum = {1'b0, i_movie_start} + {1'b0, i_movie_frames};
  assign last_frame = (last_sum > {1'b0, LAST_FRAME}) ? LAST_FRAME : last_sum[2:0];

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st <= ST_IDLE;
      movie_prev <= 1'b0;
      o_frame_sel <= 3'h0;
      o_movie_busy <= 1'b0;
    end else if (i_clk_en) begin
      movie_prev <= i_movie_req;
      case (st)
        ST_IDLE: begin
          if (i_movie_req && !movie_prev) begin
            st <= ST_MOVIE;
            o_frame_sel <= i_movie_start;
            o_movie_busy <= 1'b1;
          end else if (i_picture_req) begin
            st <= ST_PICTURE;
            o_frame_sel <= i_picture_frame;
          end
        end
        ST_MOVIE: begin
          if (hold_expire) begin
            if (o_frame_sel >= last_frame) begin
              o_movie_busy <= 1'b0;
              if (i_picture_req) begin
                st <= ST_PICTURE;
                o_frame_sel <= i_picture_frame;
              end else begin
                st <= ST_IDLE;
              end
            end else begin
              o_frame_sel <= o_frame_sel + 3'h1;
            end
          end
        end
        ST_PICTURE: begin
          o_frame_sel <= i_picture_frame;
          if (!i_picture_req) begin
            st <= ST_IDLE;
          end
        end
        default: st <= ST_IDLE;
      endcase
    end
  end

  // Intensity source follows the displayed frame only in per-frame mode.
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_intensity_frame <= 3'h0;
    end else if (i_clk_en) begin
      o_intensity_frame <= disp_opt.per_frame_int ? o_frame_sel : 3'h0;
    end
  end

  // Blink: phase restarts at the chosen level whenever blinking is off.
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      blink_cnt <= 32'h0;
      blink_phase <= 1'b1;
      o_leds_on <= 1'b1;
    end else if (i_clk_en) begin
      o_leds_on <= !i_blink_en || blink_phase;
      if (!i_blink_en) begin
        blink_cnt <= 32'h0;
        blink_phase <= !disp_opt.start_off;
      end else if (blink_cnt == (disp_opt.long_blink ? 32'(BLINK_LONG_HALF - 1)
                                                     : 32'(BLINK_SHORT_HALF - 1))) begin
        blink_cnt <= 32'h0;
        blink_phase <= !blink_phase;
      end else begin
        blink_cnt <= blink_cnt + 32'h1;
      end
    end
  end

  property p_line_bound;
    o_line_sel <= LINE_TOP && (!o_two_matrix || !layout.two_matrix || o_line_sel <= 5'h08);
  endproperty
  a_line_bound: assert property (p_line_bound) else $error("scan line out of range");
  property p_reset_opts;
    $fell(i_sys_rst) |-> disp_opt == DISP_OPT_RST;
  endproperty
  a_reset_opts: assert property (p_reset_opts) else $error("display options reset wrong");
  property p_hold_write;
    (i_clk_en && i_reg_wr && i_reg_addr == REG_FRAME_HOLD)
      |=> frame_hold == ($past(i_reg_wdata) & FRAME_HOLD_MASK);
  endproperty
  a_hold_write: assert property (p_hold_write) else $error("frame hold write lost");
  property p_shared_int;
    (i_clk_en && !disp_opt.per_frame_int && !i_reg_wr) |=> o_intensity_frame == 3'h0;
  endproperty
  a_shared_int: assert property (p_shared_int) else $error("intensity not from frame 0");
  property p_sync_dir;
    i_clk_en |=> o_sync_oe == ($past(layout.sync) == SYNC_OUT);
  endproperty
  a_sync_dir: assert property (p_sync_dir) else $error("sync pin direction wrong");
  property p_once;
    (i_clk_en && st == ST_MOVIE && frame_hold[3:0] == 4'h0 && refresh_pulse &&
     o_frame_sel < last_frame) |=> o_frame_sel == $past(o_frame_sel) + 3'h1;
  endproperty
  a_once: assert property (p_once) else $error("zero code not one refresh");
  property p_hold_frame;
    (st == ST_MOVIE && !hold_expire) |=> $stable(o_frame_sel);
  endproperty
  a_hold_frame: assert property (p_hold_frame) else $error("frame advanced early");
  property p_movie_first;
    (i_clk_en && st == ST_MOVIE && hold_expire && o_frame_sel >= last_frame && i_picture_req)
      |=> st == ST_PICTURE;
  endproperty
  a_movie_first: assert property (p_movie_first) else $error("picture not after movie");
  property p_blink_start;
    (i_clk_en && !i_blink_en) |=> blink_phase == !$past(disp_opt.start_off);
  endproperty
  a_blink_start: assert property (p_blink_start) else $error("blink start level wrong");
  c_refresh: cover property (refresh_pulse);
  c_movie_pic: cover property (st == ST_MOVIE ##1 st == ST_PICTURE);
  c_three_grp: cover property (o_line_sel == GROUP2_FIRST);
endmodule

// >>> led_sync_peer.sv
/*
  Second driver seen across the shared sync pin, driving a scan clock while master.
  Assumes the bench clock and a pull-down on the shared pin when nobody drives it.
*/
`timescale 1ns/1ps
module led_sync_peer #(
  parameter int HALF = 2
) (
  // Clock and role
  input wire logic i_core_clk,
  input wire logic i_master,
  // Sync pin drive
  output logic o_sync_out,
  output logic o_sync_oe
);
  int cnt = 0;
  // Only one driver may own the sync clock, so this one drives only when asked to.
  always @(posedge i_core_clk) begin
    o_sync_oe <= i_master;
    cnt <= (cnt + 1) % (2 * HALF);
    o_sync_out <= i_master && (cnt < HALF);
  end
endmodule

// >>> test_led_frame_scan.sv
/*
  Self-checking bench for the frame hold, scan and layout configuration block.
  Assumes the package and the block compile first; counts are shortened by parameters.
*/
`timescale 1ns/1ps
module test_led_frame_scan import led_scan_pkg::*; ();
  localparam int LC = 8, FS = 20, BS = 10, BL = 20;
  logic i_core_clk = 0, i_sys_rst = 1, i_clk_en = 1, i_reg_wr = 0, i_reg_rd = 0;
  logic [7:0] i_reg_addr = 0, i_reg_wdata = 0, o_reg_rdata;
  logic i_movie_req = 0, i_picture_req = 0, i_blink_en = 0, peer_master = 0;
  logic [2:0] i_movie_start = 0, i_movie_frames = 0, i_picture_frame = 0;
  logic sync_wire, peer_out, peer_oe, o_sync_out, o_sync_oe;
  logic o_leds_on, o_two_matrix, o_movie_busy;
  logic [4:0] o_line_sel;
  logic [2:0] o_frame_sel, o_intensity_frame;
  logic [7:0] regs [256];
  int error_cnt = 0, total_checks = 0, cycles = 0, seed = 67;
  always #10 i_core_clk = ~i_core_clk;
  // Whichever side enables drives the pin, the block first if both do; otherwise the pull-down wins.
  assign sync_wire = o_sync_oe ? o_sync_out : (peer_oe ? peer_out : 1'b0);
  led_frame_scan #(.LINE_CYCLES(LC), .FRAME_STEP_CYCLES(FS), .BLINK_SHORT_HALF(BS),
    .BLINK_LONG_HALF(BL)) led_frame_scan_inst (.i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .i_movie_req(i_movie_req), .i_picture_req(i_picture_req),
    .i_movie_start(i_movie_start), .i_movie_frames(i_movie_frames),
    .i_picture_frame(i_picture_frame), .i_blink_en(i_blink_en), .i_sync_in(sync_wire),
    .o_sync_out(o_sync_out), .o_sync_oe(o_sync_oe), .o_line_sel(o_line_sel),
    .o_frame_sel(o_frame_sel), .o_intensity_frame(o_intensity_frame),
    .o_leds_on(o_leds_on), .o_two_matrix(o_two_matrix), .o_movie_busy(o_movie_busy));
  led_sync_peer led_sync_peer_inst (.i_core_clk(i_core_clk), .i_master(peer_master),
    .o_sync_out(peer_out), .o_sync_oe(peer_oe));

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    total_checks++;
    if (exp !== got) begin
      error_cnt++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge i_core_clk);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1;
    @(negedge i_core_clk);
    i_reg_wr = 0;
    // Reserved bits never store, and unmapped places keep reading zero.
    if (a == 8'h02) regs[a] = d & 8'h0f;
    if (a == 8'h03) regs[a] = d & 8'h7f;
    if (a == 8'h04) regs[a] = d & 8'h07;
  endtask
  task automatic rd(logic [7:0] a);
    @(negedge i_core_clk);
    i_reg_addr = a;
    i_reg_rd = 1;
    @(negedge i_core_clk);
    i_reg_rd = 0;
    check("register read", {24'h0, regs[a]}, {24'h0, o_reg_rdata});
  endtask
  function automatic logic [17:0] exp_lines(logic [3:0] code, logic two);
    int k;
    exp_lines = 18'h0;
    k = two ? (code > 8 ? 8 : code) : (code > 5 ? 5 : code);
    for (int i = 0; i <= k; i++) begin
      exp_lines[i] = 1'b1;
      if (!two) exp_lines[i + 6] = 1'b1;
      if (!two) exp_lines[i + 12] = 1'b1;
    end
  endfunction
  task automatic scan(logic [3:0] code, logic [1:0] sync, logic two);
    logic [17:0] seen;
    logic [4:0] prev;
    int steps, highs;
    seen = 18'h0;
    steps = 0;
    highs = 0;
    wr(8'h03, {4'h0, code});
    wr(8'h04, {5'h00, sync, two});
    peer_master = (sync == 2'b10);
    repeat (2 * 18 * LC) @(negedge i_core_clk);
    prev = o_line_sel;
    repeat (2 * 18 * LC) begin
      @(negedge i_core_clk);
      seen[o_line_sel] = 1'b1;
      steps += (o_line_sel !== prev);
      highs += (o_sync_out === 1'b1);
      prev = o_line_sel;
    end
    check("scanned lines", exp_lines(code, two), seen);
    check("layout", two, o_two_matrix);
    check("sync drive", sync == 2'b01, o_sync_oe);
    if (sync == 2'b01 && !(two && code == 0)) check("line steps", 36, steps);
    if (sync == 2'b01) check("sync high cycles", 18 * LC, highs);
    peer_master = 0;
    i_clk_en = (sync != 2'b01);
    repeat (4) @(negedge i_core_clk);
    prev = o_line_sel;
    repeat (40) @(negedge i_core_clk);
    check("line frozen", prev, o_line_sel);
    i_clk_en = 1;
  endtask
  task automatic movie(logic [2:0] st, logic [2:0] nf, logic [3:0] code, logic per);
    int cnt, last;
    last = (st + nf > 5) ? 5 : st + nf;
    wr(8'h02, {4'h0, code});
    wr(8'h03, {1'b0, per, 6'h07});
    i_movie_start = st;
    i_movie_frames = nf;
    i_picture_req = per;
    i_picture_frame = 3'(last ^ 1);
    i_movie_req = 1;
    cnt = 0;
    while (o_movie_busy !== 1'b1 && cnt < 5) begin
      @(negedge i_core_clk);
      cnt++;
    end
    for (int f = st; f <= last; f++) begin
      check("frame", f, o_frame_sel);
      cnt = 0;
      while (o_frame_sel === 3'(f) && o_movie_busy === 1'b1 && cnt < 400) begin
        @(negedge i_core_clk);
        cnt++;
        if (cnt == 2) check("intensity frame", per ? f : 0, o_intensity_frame);
      end
      if (code != 0) check("frame hold", code * FS, cnt);
      else if (f > st) check("single pass", LINES_ALL * LC, cnt);
      else check("single pass", 1, cnt > 0 && cnt < 400);
    end
    i_movie_req = 0;
    @(negedge i_core_clk);
    check("movie done", 0, o_movie_busy);
    if (per) check("picture after movie", last ^ 1, o_frame_sel);
    i_picture_req = 0;
    repeat (3) @(negedge i_core_clk);
  endtask
  task automatic blink(logic off, logic lng);
    int cnt;
    wr(8'h03, {2'b00, off, lng, 4'h7});
    // One idle edge lets the new start level load before blinking begins.
    @(negedge i_core_clk);
    i_blink_en = 1;
    repeat (3) @(negedge i_core_clk);
    check("blink start", !off, o_leds_on);
    cnt = 0;
    while (o_leds_on === !off && cnt < 50) begin
      @(negedge i_core_clk);
      cnt++;
    end
    check("blink first half", (lng ? BL : BS) - 2, cnt);
    cnt = 0;
    while (o_leds_on === off && cnt < 50) begin
      @(negedge i_core_clk);
      cnt++;
    end
    check("blink half period", lng ? BL : BS, cnt);
    i_blink_en = 0;
    repeat (3) @(negedge i_core_clk);
  endtask

  initial begin
    logic [7:0] d;
    for (int a = 0; a < 256; a++) regs[a] = 8'h00;
    regs[3] = 8'h07;
    repeat (6) @(negedge i_core_clk);
    i_sys_rst = 0;
    for (int a = 1; a <= 5; a++) rd(8'(a));
    for (int a = 1; a <= 5; a++) begin
      d = 8'($random(seed));
      if (a == 4) d[2:1] = 2'b01;
      wr(8'(a), d);
      rd(8'(a));
    end
    for (int c = 0; c < 32; c++) begin
      d[1:0] = ($random(seed) & 1) ? 2'b01 : 2'b10;
      scan(4'(c), d[1:0], c[4]);
    end
    // Three-matrix layout with the internal line clock, so a full pass is 18 lines.
    wr(8'h04, 8'h02);
    for (int m = 0; m < 5; m++) begin
      movie(3'($random(seed) & 3), 3'($random(seed) & 3), 4'(m % 4), m[0]);
    end
    i_picture_frame = 3'h3;
    i_picture_req = 1;
    repeat (2) @(negedge i_core_clk);
    check("picture only", 3, o_frame_sel);
    check("picture busy", 0, o_movie_busy);
    i_picture_req = 0;
    repeat (3) @(negedge i_core_clk);
    for (int b = 0; b < 4; b++) blink(b[1], b[0]);
    tally_and_finish();
  end
endmodule
